// File: esmd_top.sv
/*
 * top of the extended protected-ram decode block: register port, lock,
 * request routing and registered outputs.
 * assumes the global enable, open bit and dram top come from sibling
 * registers of the controller, and requests arrive one per cycle.
 */
`timescale 1ns/1ps
module esmd_top
  import esmd_pkg::*;
(
  input  wire logic       core_clk,     // controller clock, 25 MHz
  input  wire logic       resetn,       // full reset, active low
  input  wire logic       cfg_wr,       // config write strobe
  input  wire logic       cfg_rd,       // config read strobe
  input  wire logic [7:0] cfg_addr,     // config byte offset
  input  wire logic [7:0] cfg_wdata,    // config write data
  output      logic [7:0] cfg_rdata,    // config read data, registered
  output      logic       cfg_rvalid,   // read data valid pulse
  input  wire logic       global_en,    // global_protected_ram_enable
  input  wire logic       open_bit,     // region open bit
  input  wire logic       lock_set,     // write of one to the region_lock bit
  input  wire logic [4:0] dram_top,     // low_usable_dram_top
  input  wire esmd_req_s  host_req,     // processor request
  output      esmd_rsp_s  route_q,      // routed request, registered
  output      logic       lock_q,       // region_lock state
  output      logic       high_en_o,    // high_region_enable
  output      logic       seg_en_o,     // top_segment_enable_alias
  output      logic       err_o         // illegal_access_flag
);

  logic       reg_wr;
  logic [7:0] reg_value;
  esmd_ctx_s  ctx;
  esmd_rsp_s  rsp;

  assign reg_wr = cfg_wr && (cfg_addr == ESMD_CTRL_OFFSET);

  always_comb begin
    ctx.global_en = global_en;
    ctx.open      = open_bit && !lock_q;
    ctx.lock      = lock_q;
    ctx.top       = dram_top;
  end

  // ************************************************************
  // lock
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lock_q <= 1'b0;
    end else if (lock_set) begin
      lock_q <= 1'b1;
    end
  end

  esmd_reg u_reg (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr_en    (reg_wr),
    .wr_data  (cfg_wdata),
    .lock     (lock_q),
    .illegal  (rsp.illegal),
    .value    (reg_value)
  );

  esmd_decode u_dec (
    .req      (host_req),
    .ctx      (ctx),
    .high_en  (reg_value[ESMD_HIGH_EN_BIT]),
    .seg_en   (reg_value[ESMD_TOP_EN_BIT]),
    .seg_size (reg_value[ESMD_SIZE_HI_BIT:ESMD_SIZE_LO_BIT]),
    .rsp      (rsp)
  );

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      route_q <= '0;
    end else begin
      route_q <= rsp;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rdata  <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
      // unmapped offsets read zero
      cfg_rdata  <= (cfg_rd && cfg_addr == ESMD_CTRL_OFFSET) ? reg_value : 8'h00;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_en_o <= 1'b0;
      seg_en_o  <= 1'b0;
      err_o     <= 1'b0;
    end else begin
      high_en_o <= reg_value[ESMD_HIGH_EN_BIT];
      seg_en_o  <= reg_value[ESMD_TOP_EN_BIT];
      err_o     <= reg_value[ESMD_ERR_BIT];
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_lock_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    lock_q |=> lock_q) else $error("lock cleared without reset");

  a_high_locked: assert property (@(posedge core_clk) disable iff (!resetn)
    lock_q |=> $stable(reg_value[ESMD_HIGH_EN_BIT])) else $error("high enable changed while locked");

  a_size_locked: assert property (@(posedge core_clk) disable iff (!resetn)
    lock_q |=> $stable(reg_value[ESMD_SIZE_HI_BIT:ESMD_SIZE_LO_BIT])) else $error("size changed while locked");

  a_seg_locked: assert property (@(posedge core_clk) disable iff (!resetn)
    lock_q |=> $stable(reg_value[ESMD_TOP_EN_BIT])) else $error("segment enable changed while locked");

  a_ones_fixed: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_value[ESMD_CACHE_BIT:ESMD_L2_BIT] == 3'h7) else $error("cache indicators not one");

  a_err_sets: assert property (@(posedge core_clk) disable iff (!resetn)
    rsp.illegal |=> reg_value[ESMD_ERR_BIT] ##1 err_o) else $error("illegal access not flagged");

  a_err_holds: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_value[ESMD_ERR_BIT] && !(reg_wr && cfg_wdata[ESMD_ERR_BIT]) |=> reg_value[ESMD_ERR_BIT])
    else $error("flag dropped without write of one");

  a_err_clear: assert property (@(posedge core_clk) disable iff (!resetn)
    reg_wr && cfg_wdata[ESMD_ERR_BIT] && !rsp.illegal |=> !reg_value[ESMD_ERR_BIT])
    else $error("write of one did not clear flag");

  a_high_remap: assert property (@(posedge core_clk) disable iff (!resetn)
    host_req.valid && global_en && reg_value[ESMD_HIGH_EN_BIT] && host_req.addr == ESMD_HIGH_BASE
    |=> route_q.addr == ESMD_LEGACY_BASE && route_q.to_dram) else $error("high window not remapped");

  a_no_global: assert property (@(posedge core_clk) disable iff (!resetn)
    host_req.valid && !global_en |=> !route_q.illegal) else $error("extended decode active without global enable");

  // an illegal hit that was not remapped can only be a top segment hit, which must go to the link
  a_untagged_link: assert property (@(posedge core_clk) disable iff (!resetn)
    rsp.illegal && rsp.addr == host_req.addr |=> !route_q.to_dram)
    else $error("untagged protected request reached dram");

endmodule

// File: esmd_pkg.sv
/*
 * package for the extended protected-ram decode block: register offset,
 * field positions, reset value, address windows and carrier structs.
 * assumes a single core_clk domain; no timing counts are needed.
 */
package esmd_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ESMD_CTRL_OFFSET   = 8'h9e;
  localparam logic [7:0] ESMD_CTRL_RESET    = 8'h38;
  localparam int         ESMD_HIGH_EN_BIT   = 7;
  localparam int         ESMD_ERR_BIT       = 6;
  localparam int         ESMD_CACHE_BIT     = 5;
  localparam int         ESMD_L1_BIT        = 4;
  localparam int         ESMD_L2_BIT        = 3;
  localparam int         ESMD_SIZE_HI_BIT   = 2;
  localparam int         ESMD_SIZE_LO_BIT   = 1;
  localparam int         ESMD_TOP_EN_BIT    = 0;

  // ************************************************************
  // address windows
  // ************************************************************
  localparam logic [31:0] ESMD_HIGH_BASE    = 32'hfeda0000;
  localparam logic [31:0] ESMD_HIGH_LAST    = 32'hfedbffff;
  localparam logic [31:0] ESMD_LEGACY_BASE  = 32'h000a0000;
  localparam logic [31:0] ESMD_SEG_1MB      = 32'h00100000;
  localparam logic [31:0] ESMD_SEG_2MB      = 32'h00200000;
  localparam logic [31:0] ESMD_SEG_8MB      = 32'h00800000;
  localparam logic [1:0]  ESMD_SZ_1MB       = 2'h0;
  localparam logic [1:0]  ESMD_SZ_2MB       = 2'h1;
  localparam logic [1:0]  ESMD_SZ_8MB       = 2'h2;
  localparam int          ESMD_TOP_LSB      = 27;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        mgmt;      // request tagged as management mode
  } esmd_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;      // address after remap
    logic        to_dram;   // 1: dram, 0: south bridge link
    logic        illegal;   // protected range touched outside management mode
  } esmd_rsp_s;

  typedef struct packed {
    logic       global_en;
    logic       open;
    logic       lock;
    logic [4:0] top;        // low_usable_dram_top, address bits 31:27
  } esmd_ctx_s;

endpackage

// File: esmd_decode.sv
/*
 * combinational address decode for the high alias window and the top segment.
 * assumes control inputs are stable register outputs of the same clock domain.
 */
`timescale 1ns/1ps
module esmd_decode
  import esmd_pkg::*;
(
  input  wire esmd_req_s  req,          // incoming processor request
  input  wire esmd_ctx_s  ctx,          // global enable, open, lock, dram top
  input  wire logic       high_en,      // high_region_enable
  input  wire logic       seg_en,       // top_segment_enable_alias
  input  wire logic [1:0] seg_size,     // top_segment_size
  output      esmd_rsp_s  rsp           // routed request
);

  logic [31:0] top_addr;
  logic [31:0] seg_len;
  logic [31:0] seg_base;
  logic        in_high;
  logic        in_seg;

  always_comb begin
    top_addr = {ctx.top, 27'h0000000};
    case (seg_size)
      ESMD_SZ_1MB: seg_len = ESMD_SEG_1MB;
      ESMD_SZ_2MB: seg_len = ESMD_SEG_2MB;
      ESMD_SZ_8MB: seg_len = ESMD_SEG_8MB;
      default:     seg_len = 32'h00000000; // reserved code decodes no segment
    endcase
    seg_base = top_addr - seg_len;
    in_high  = ctx.global_en && high_en && req.addr >= ESMD_HIGH_BASE && req.addr <= ESMD_HIGH_LAST;
    in_seg   = ctx.global_en && seg_en && (seg_len != 32'h0) && req.addr >= seg_base
               && req.addr < top_addr;
    rsp.valid   = req.valid;
    rsp.addr    = in_high ? (req.addr - ESMD_HIGH_BASE + ESMD_LEGACY_BASE) : req.addr;
    // high window hits and unprotected addresses below the dram top go to dram, segment hits only when tagged, the rest to the link
    rsp.to_dram = in_seg ? req.mgmt : (in_high || req.addr < top_addr);
    rsp.illegal = req.valid && (in_high || in_seg) && !req.mgmt && !ctx.open;
  end

endmodule

// File: esmd_reg.sv
/*
 * the control register itself with its locked, sticky and forced-one fields.
 * assumes writes and the illegal event are single-cycle qualified pulses.
 */
`timescale 1ns/1ps
module esmd_reg
  import esmd_pkg::*;
(
  input  wire logic       core_clk,     // controller clock
  input  wire logic       resetn,       // full reset, active low
  input  wire logic       wr_en,        // config write strobe to this register
  input  wire logic [7:0] wr_data,      // config write data
  input  wire logic       lock,         // region_lock
  input  wire logic       illegal,      // illegal access event
  output      logic [7:0] value         // current register value
);

  logic       high_en_q;
  logic       err_q;
  logic [1:0] size_q;
  logic       seg_en_q;

  // ************************************************************
  // lockable fields
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      high_en_q <= ESMD_CTRL_RESET[ESMD_HIGH_EN_BIT];
      size_q    <= ESMD_CTRL_RESET[ESMD_SIZE_HI_BIT:ESMD_SIZE_LO_BIT];
      seg_en_q  <= ESMD_CTRL_RESET[ESMD_TOP_EN_BIT];
    end else if (wr_en && !lock) begin
      high_en_q <= wr_data[ESMD_HIGH_EN_BIT];
      size_q    <= wr_data[ESMD_SIZE_HI_BIT:ESMD_SIZE_LO_BIT];
      seg_en_q  <= wr_data[ESMD_TOP_EN_BIT];
    end
  end

  // ************************************************************
  // sticky flag: a new event wins over a clear in the same cycle
  // ************************************************************
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      err_q <= ESMD_CTRL_RESET[ESMD_ERR_BIT];
    end else if (illegal) begin
      err_q <= 1'b1;
    end else if (wr_en && wr_data[ESMD_ERR_BIT]) begin
      err_q <= 1'b0;
    end
  end

  always_comb begin
    value = {high_en_q, err_q, 3'h7, size_q, seg_en_q};
  end

endmodule

// File: esmd_host_model.sv
/*
 * processor host model: issues one tagged memory request per go pulse.
 * assumes go, addr and mgmt change just after a core_clk rising edge.
 */
`timescale 1ns/1ps
module esmd_host_model
  import esmd_pkg::*;
(
  input  wire logic        core_clk,  // controller clock
  input  wire logic        resetn,    // full reset, active low
  input  wire logic        go,        // issue one request
  input  wire logic [31:0] addr,      // request address
  input  wire logic        mgmt,      // management-mode tag
  output      esmd_req_s   req        // request into the block
);
  // idle cycles flip the stale address and tag so nothing can lean on them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      req <= '0;
    end else if (go) begin
      req <= '{valid: 1'b1, addr: addr, mgmt: mgmt};
    end else begin
      req <= '{valid: 1'b0, addr: ~req.addr, mgmt: ~req.mgmt};
    end
  end
endmodule

// File: testbench.sv
/*
 * self-checking bench for the extended protected-ram decode block.
 * assumes the sibling enable, open, lock and dram top inputs are bench driven.
 */
`timescale 1ns/1ps
module testbench;
  import esmd_pkg::*;
  logic        core_clk = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, go = 0, mgmt = 0;
  logic        global_en = 0, open_bit = 0, lock_set = 0, lock_v = 0;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, exp_reg, cfg_rdata;
  logic [4:0]  dram_top = 5'h10;
  logic [31:0] addr = 32'h0, rnd = 32'h2add, a, sz;
  logic        cfg_rvalid, lock_q, high_en_o, seg_en_o, err_o;
  esmd_req_s   host_req;
  esmd_rsp_s   route_q, e;
  int          err_count = 0, n_tests = 0, cycles = 0;

  esmd_host_model u_host (.core_clk, .resetn, .go, .addr, .mgmt, .req(host_req));
  esmd_top dut (.core_clk, .resetn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .cfg_rvalid, .global_en, .open_bit, .lock_set, .dram_top, .host_req, .route_q,
    .lock_q, .high_en_o, .seg_en_o, .err_o);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string n, input logic [39:0] x, input logic [39:0] g);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] seg_bytes(input logic [1:0] c);
    return (c == 2'h0) ? ESMD_SEG_1MB : (c == 2'h1) ? ESMD_SEG_2MB : ESMD_SEG_8MB;
  endfunction

  function automatic esmd_rsp_s exp_rsp(input logic [31:0] x, input logic m);
    esmd_rsp_s r;
    logic [31:0] t;
    logic hi, sg;
    t = {dram_top, 27'h0};
    hi = global_en & exp_reg[7] & x >= ESMD_HIGH_BASE & x <= ESMD_HIGH_LAST;
    sg = global_en & exp_reg[0] & exp_reg[2:1] != 2'h3 & x >= t - seg_bytes(exp_reg[2:1]) & x < t;
    r.valid = 1'b1;
    r.addr = hi ? ESMD_LEGACY_BASE + (x - ESMD_HIGH_BASE) : x;
    r.to_dram = hi | (sg ? m : x < t);
    r.illegal = (hi | sg) & !m & !(open_bit & !lock_v);
    return r;
  endfunction

  task wr(input logic [7:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= ESMD_CTRL_OFFSET;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    exp_reg[6] = exp_reg[6] & ~d[6];
    if (!lock_v) exp_reg = {d[7], exp_reg[6], 3'h7, d[2:0]};
  endtask

  task rd(input logic [7:0] ad, input logic [7:0] x);
    @(posedge core_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= ad;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1;
    chk("cfg_rvalid", 40'h1, {39'h0, cfg_rvalid});
    chk("cfg_rdata", {32'h0, x}, {32'h0, cfg_rdata});
  endtask

  task req(input logic [31:0] ra, input logic m);
    @(posedge core_clk);
    go <= 1'b1;
    addr <= ra;
    mgmt <= m;
    @(posedge core_clk);
    go <= 1'b0;
    e = exp_rsp(ra, m);
    @(posedge core_clk);
    #1;
    chk("route_q", {5'h0, e}, {5'h0, route_q});
    if (e.illegal) exp_reg[6] = 1'b1;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    exp_reg = ESMD_CTRL_RESET;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ESMD_CTRL_OFFSET, 8'h38);
    rd(8'h9d, 8'h00);
    wr(8'hff);
    rd(ESMD_CTRL_OFFSET, exp_reg);
    $display("test fields done");
    wr(8'h81);
    repeat (2) @(posedge core_clk);
    #1;
    chk("high_en_o", 40'h1, {39'h0, high_en_o});
    chk("seg_en_o", 40'h1, {39'h0, seg_en_o});
    for (int g = 0; g < 2; g++) begin
      @(posedge core_clk);
      global_en <= g[0];
      req(ESMD_HIGH_BASE + {14'h0, rnd[17:0]}, 1'b1);
      rnd = lfsr(rnd);
    end
    $display("test remap done");
    for (int s = 0; s < 4; s++) begin
      wr({5'h1c, s[1:0], 1'b1});
      @(posedge core_clk);
      dram_top <= rnd[4:0] | 5'h01;
      rnd = lfsr(rnd);
      @(posedge core_clk);
      sz = {dram_top, 27'h0} - seg_bytes(s[1:0]);
      req(sz, 1'b1);
      req(sz, 1'b0);
      req(sz - 32'h1, 1'b0);
      req({dram_top, 27'h0} - 32'h1, 1'b0);
    end
    // the reserved size code above leaves the flag clear, so raise it here before the clear tests
    req(ESMD_HIGH_BASE, 1'b0);
    repeat (2) @(posedge core_clk);
    #1;
    chk("err_o", {39'h0, exp_reg[6]}, {39'h0, err_o});
    rd(ESMD_CTRL_OFFSET, exp_reg);
    wr(exp_reg & 8'hbf);
    rd(ESMD_CTRL_OFFSET, exp_reg);
    wr(exp_reg | 8'h40);
    rd(ESMD_CTRL_OFFSET, exp_reg);
    $display("test segment done");
    // a real segment size, so random and locked requests can land in the segment
    wr(8'h83);
    repeat (24) begin
      @(posedge core_clk);
      global_en <= rnd[8];
      open_bit <= rnd[9];
      a = rnd[1] ? ESMD_HIGH_BASE + {14'h0, rnd[31:14]} : {dram_top, 27'h0} - {12'h0, rnd[31:12]};
      req(a, rnd[3]);
      rnd = lfsr(rnd);
    end
    rd(ESMD_CTRL_OFFSET, exp_reg);
    $display("test random done");
    @(posedge core_clk);
    global_en <= 1'b1;
    open_bit <= 1'b1;
    lock_set <= 1'b1;
    @(posedge core_clk);
    lock_set <= 1'b0;
    lock_v = 1'b1;
    @(posedge core_clk);
    #1;
    chk("lock_q", 40'h1, {39'h0, lock_q});
    wr(8'h40);
    rd(ESMD_CTRL_OFFSET, exp_reg);
    req({dram_top, 27'h0} - 32'h1, 1'b0);
    $display("test lock done");
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    lock_v = 1'b0;
    exp_reg = ESMD_CTRL_RESET;
    #1;
    chk("lock_q", 40'h0, {39'h0, lock_q});
    rd(ESMD_CTRL_OFFSET, 8'h38);
    $display("test reset done");
    test_done();
  end
endmodule
